// file: include/poc_pkg.sv
// package for the pluggable optic control pin logic
// assumes a 25 MHz system clock and a synchronous active-high reset
package poc_pkg;
  // clock rate in MHz, period 40 ns
  localparam int unsigned CLK_MHZ = 25;
  // laser-off to optical output below 10 %, longest time in us
  localparam int unsigned T_OFF_US = 10;
  localparam int unsigned OFF_CYC = T_OFF_US * CLK_MHZ;
  // laser-off release to modulated output above 90 %, longest time in ms
  localparam int unsigned T_ON_MS = 1;
  localparam int unsigned ON_CYC = T_ON_MS * 1000 * CLK_MHZ;
  // initialisation time, longest, in ms
  localparam int unsigned T_INIT_MS = 300;
  localparam int unsigned INIT_CYC = T_INIT_MS * 1000 * CLK_MHZ;
  // fault flag assert time, longest, in us
  localparam int unsigned T_FAULT_US = 100;
  localparam int unsigned FAULT_CYC = T_FAULT_US * CLK_MHZ;
  // least hold time of laser-off that clears a latched fault, in us
  localparam int unsigned T_RESET_US = 10;
  localparam int unsigned RESET_CYC = T_RESET_US * CLK_MHZ;
  // loss-of-signal assert and deassert times, longest, in us
  localparam int unsigned T_LOSS_US = 100;
  localparam int unsigned LOSS_CYC = T_LOSS_US * CLK_MHZ;
  // id link: seven-bit device address of the diagnostic page
  localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;
  // status/control byte and its bit positions
  localparam logic [7:0] STATUS_BYTE_ADDR = 8'h6e;
  localparam int unsigned FAULT_BIT = 2;
  localparam int unsigned RX_LOW_BIT = 1;
  localparam int unsigned NOT_READY_BIT = 0;
  // reset values
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // live state mirrored into the status byte
  typedef struct packed {
    logic fault;
    logic rx_low;
    logic not_ready;
  } poc_status_t;

  // open-drain pin: output level and enable
  typedef struct packed {
    logic out;
    logic oe;
  } poc_od_t;

  typedef enum logic [2:0] {
    POC_IDLE,
    POC_RX,
    POC_ACK_OUT,
    POC_TX,
    POC_ACK_IN
  } poc_id_state_t;

  typedef enum logic [1:0] {
    POC_PH_DEV,
    POC_PH_WORD,
    POC_PH_DATA
  } poc_phase_t;
endpackage

// file: core/poc_ctrl.sv
// control pin logic of a pluggable optical transceiver: laser-off request,
// latched laser fault, received-power loss flag, presence strap and the
// two-wire identification link serving the diagnostic status byte
// assumes pins arrive asynchronous to clk_sys; open-drain pins are resolved
// outside from out/oe; fault and loss sensors are level signals from analog

// Operation
// R1: the transmitter is on only while the laser-off request is low, off while high or open.
// R2: the fault pin is pulled low in normal operation and released high on a laser fault.
// R3: the presence strap is always driven to ground.
// R4: identification travels on a two-wire link, a clock line and a bidirectional data line.
// R5: the speed choice pin is ignored and no rate selection is needed.
// R6: the loss flag is low while received power is adequate and high when it is too low.
// R7: a rising laser-off request turns the optical output off within 10 us.
// R8: a falling laser-off request turns the optical output on within 1 ms.
// R9: initialisation, with the fault flag cleared, ends within 300 ms of power-on or fault clear.
// R10: the fault flag rises within 100 us of a laser fault.
// R11: a laser-off request held high for at least 10 us clears a latched fault.
// R12: the loss flag rises within 100 us of entering loss of signal.
// R13: the loss flag falls within 100 us of power returning.
// R14: the host clocks the identification link no faster than 100 kHz.
// R15: the fault state is mirrored into bit 2 of diagnostic byte 110.
// R16: the loss state is mirrored into bit 1 of diagnostic byte 110.
// R17: a fault stays latched until a qualifying clear pulse or a power cycle.
module poc_ctrl
  import poc_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_CYC,
  parameter int unsigned CLEAR_CYCLES = RESET_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic laser_off_request,
  input wire logic laser_fault_detect,
  input wire logic rx_power_detect_low,
  input wire logic id_link_clock_line,
  input wire logic id_link_data_line_in,
  output logic id_link_data_line_out,
  output logic id_link_data_line_oe,
  output logic laser_enable,
  output logic laser_fault_flag_out,
  output logic laser_fault_flag_oe,
  output logic rx_power_low_flag_out,
  output logic rx_power_low_flag_oe,
  output logic presence_strap_out,
  output logic presence_strap_oe
);
  // counter widths follow the configured cycle counts
  localparam int unsigned IW = $clog2(INIT_CYCLES + 1);
  localparam int unsigned CW = $clog2(CLEAR_CYCLES + 1);

  // status byte as read over the id link
  function automatic logic [7:0] status_byte(input logic [7:0] ptr, input poc_status_t st);
    logic [7:0] b;
    b = BYTE_ZERO;
    if (ptr == STATUS_BYTE_ADDR) begin
      b[FAULT_BIT] = st.fault; // [R15]
      b[RX_LOW_BIT] = st.rx_low; // [R16]
      b[NOT_READY_BIT] = st.not_ready;
    end
    return b;
  endfunction

  // two-flop synchronisers for every pin and sensor input
  logic [1:0] req_sync_reg, fdet_sync_reg, rxl_sync_reg, scl_sync_reg, sda_sync_reg;
  logic scl_prev_reg, sda_prev_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req_sync_reg <= 2'h3; // an open request reads high
      fdet_sync_reg <= 2'h0;
      rxl_sync_reg <= 2'h0;
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'h1;
      sda_prev_reg <= 1'h1;
    end else begin
      req_sync_reg <= {req_sync_reg[0], laser_off_request};
      fdet_sync_reg <= {fdet_sync_reg[0], laser_fault_detect};
      rxl_sync_reg <= {rxl_sync_reg[0], rx_power_detect_low};
      scl_sync_reg <= {scl_sync_reg[0], id_link_clock_line};
      sda_sync_reg <= {sda_sync_reg[0], id_link_data_line_in};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  // only the second flop of each synchroniser is read by logic
  wire logic req_s = req_sync_reg[1];
  wire logic fdet_s = fdet_sync_reg[1];
  wire logic rxl_s = rxl_sync_reg[1];
  wire logic scl_s = scl_sync_reg[1];
  wire logic sda_s = sda_sync_reg[1];

  // laser control state
  logic fault_reg, fault_next;
  logic [IW-1:0] init_cnt_reg, init_cnt_next;
  logic [CW-1:0] hold_cnt_reg, hold_cnt_next;
  logic laser_en_reg, laser_en_next;
  logic rxl_reg, rxl_next;
  poc_status_t status;

  // fault latch, clear-pulse timer and init timer; sensing takes three
  // cycles, far inside the 10 us and 100 us limits
  always_comb begin
    hold_cnt_next = hold_cnt_reg;
    init_cnt_next = init_cnt_reg;
    fault_next = fault_reg;
    if (!req_s) begin
      hold_cnt_next = '0;
    end else if (hold_cnt_reg != CW'(CLEAR_CYCLES)) begin
      hold_cnt_next = hold_cnt_reg + CW'(1);
    end
    if (init_cnt_reg != '0) begin
      init_cnt_next = init_cnt_reg - IW'(1);
    end
    // clear needs the full hold; a live fault still sets, set wins
    if (fault_reg && req_s && hold_cnt_reg == CW'(CLEAR_CYCLES - 1)) begin // [R11] [R17]
      fault_next = 1'b0;
      init_cnt_next = IW'(INIT_CYCLES); // [R9]
    end
    if (fdet_s) begin
      fault_next = 1'b1; // [R10] [R17]
    end
    // off while request high or open, on when low and healthy
    laser_en_next = !req_s && !fault_next && (init_cnt_next == '0); // [R1] [R7] [R8]
    rxl_next = rxl_s; // [R6] [R12] [R13]
  end

  // laser control registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_reg <= 1'b0;
      init_cnt_reg <= IW'(INIT_CYCLES); // [R9]
      hold_cnt_reg <= '0;
      laser_en_reg <= 1'b0;
      rxl_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next;
      init_cnt_reg <= init_cnt_next;
      hold_cnt_reg <= hold_cnt_next;
      laser_en_reg <= laser_en_next;
      rxl_reg <= rxl_next;
    end
  end

  // live status for the byte read over the id link; one driver for the whole struct
  assign status = '{fault: fault_reg, rx_low: rxl_reg, not_ready: (init_cnt_reg != '0)};

  // open-drain flags: enable pulls low, released means high
  poc_od_t fault_pin_reg, rxl_pin_reg, strap_pin_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_pin_reg <= '{out: 1'b0, oe: 1'b1};
      rxl_pin_reg <= '{out: 1'b0, oe: 1'b1};
      strap_pin_reg <= '{out: 1'b0, oe: 1'b1};
    end else begin
      fault_pin_reg <= '{out: 1'b0, oe: !fault_next}; // [R2]
      rxl_pin_reg <= '{out: 1'b0, oe: !rxl_next}; // [R6]
      strap_pin_reg <= '{out: 1'b0, oe: 1'b1}; // [R3]
    end
  end

  // id link slave, read-only: writes only move the byte pointer
  poc_id_state_t st_reg, st_next;
  poc_phase_t ph_reg, ph_next;
  logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next;
  logic [3:0] cnt_reg, cnt_next;
  logic rd_reg, rd_next, sda_oe_reg, sda_oe_next;
  // byte at the pointer; a function result cannot be part-selected directly
  wire logic [7:0] rd_byte = status_byte(ptr_reg, status);
  // line events from synchronised copies; start and stop need the clock high twice
  wire logic scl_rise = scl_s && !scl_prev_reg;
  wire logic scl_fall = !scl_s && scl_prev_reg;
  wire logic start_c = scl_s && scl_prev_reg && !sda_s && sda_prev_reg;
  wire logic stop_c = scl_s && scl_prev_reg && sda_s && !sda_prev_reg;

  // edge-driven; relies on the host keeping the clock slow enough to sample
  always_comb begin
    st_next = st_reg;
    ph_next = ph_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    cnt_next = cnt_reg;
    rd_next = rd_reg;
    sda_oe_next = sda_oe_reg;
    if (start_c) begin // [R4]
      st_next = POC_RX;
      ph_next = POC_PH_DEV;
      cnt_next = 4'h0;
      sda_oe_next = 1'b0;
    end else if (stop_c) begin
      st_next = POC_IDLE;
      sda_oe_next = 1'b0;
    end else begin
      case (st_reg)
        POC_IDLE: begin
          sda_oe_next = 1'b0;
        end
        POC_RX: begin
          if (scl_rise && cnt_reg != 4'h8) begin
            sh_next = {sh_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            cnt_next = 4'h0;
            st_next = POC_ACK_OUT;
            sda_oe_next = 1'b1; // acknowledge by pulling low
            case (ph_reg)
              POC_PH_DEV: begin
                rd_next = sh_reg[0];
                if (sh_reg[7:1] != DIAG_DEV_ADDR) begin
                  st_next = POC_IDLE;
                  sda_oe_next = 1'b0;
                end
              end
              POC_PH_WORD: ptr_next = sh_reg;
              default: ptr_next = ptr_reg + 8'h01;
            endcase
          end
        end
        POC_ACK_OUT: begin
          // a read starts sending at once, a write goes on to the next byte
          if (scl_fall) begin
            if (ph_reg == POC_PH_DEV && rd_reg) begin
              sh_next = {rd_byte[6:0], 1'b0};
              sda_oe_next = !rd_byte[7];
              cnt_next = 4'h1;
              st_next = POC_TX;
            end else begin
              sda_oe_next = 1'b0;
              st_next = POC_RX;
              ph_next = (ph_reg == POC_PH_DEV) ? POC_PH_WORD : POC_PH_DATA;
            end
          end
        end
        POC_TX: begin
          if (scl_fall) begin
            if (cnt_reg == 4'h8) begin
              sda_oe_next = 1'b0; // let the host answer
              st_next = POC_ACK_IN;
            end else begin
              sda_oe_next = !sh_reg[7];
              sh_next = {sh_reg[6:0], 1'b0};
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        POC_ACK_IN: begin
          // host ack moves on to the next byte, a nack ends the read
          if (scl_rise) begin
            if (sda_s) begin
              st_next = POC_IDLE; // host ends the read
            end else begin
              ptr_next = ptr_reg + 8'h01;
            end
          end else if (scl_fall) begin
            sh_next = {rd_byte[6:0], 1'b0};
            sda_oe_next = !rd_byte[7];
            cnt_next = 4'h1;
            st_next = POC_TX;
          end
        end
        default: begin
          st_next = POC_IDLE;
          sda_oe_next = 1'b0;
        end
      endcase
    end
  end

  // id link registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= POC_IDLE;
      ph_reg <= POC_PH_DEV;
      sh_reg <= BYTE_ZERO;
      ptr_reg <= PTR_RST;
      cnt_reg <= 4'h0;
      rd_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      ph_reg <= ph_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      cnt_reg <= cnt_next;
      rd_reg <= rd_next;
      sda_oe_reg <= sda_oe_next;
    end
  end

  // outputs straight from flops, except the data line level, a constant low; the speed choice pin has no port at all
  assign laser_enable = laser_en_reg; // [R5]
  assign laser_fault_flag_out = fault_pin_reg.out;
  assign laser_fault_flag_oe = fault_pin_reg.oe;
  assign rx_power_low_flag_out = rxl_pin_reg.out;
  assign rx_power_low_flag_oe = rxl_pin_reg.oe;
  assign presence_strap_out = strap_pin_reg.out;
  assign presence_strap_oe = strap_pin_reg.oe;
  // data line is only ever pulled low; a one comes from the host pull-up
  assign id_link_data_line_out = 1'b0;
  assign id_link_data_line_oe = sda_oe_reg;
endmodule

// file: bench/poc_ctrl_monitor.sv
// checker for the control pin block, sees only its ports
// assumes clk_sys rising edge and rst synchronous active high
module poc_ctrl_monitor
  import poc_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = 50,
  parameter int unsigned CLEAR_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic laser_off_request,
  input wire logic laser_fault_detect,
  input wire logic rx_power_detect_low,
  input wire logic id_link_clock_line,
  input wire logic id_link_data_line_in,
  input wire logic id_link_data_line_out,
  input wire logic id_link_data_line_oe,
  input wire logic laser_enable,
  input wire logic laser_fault_flag_out,
  input wire logic laser_fault_flag_oe,
  input wire logic rx_power_low_flag_out,
  input wire logic rx_power_low_flag_oe,
  input wire logic presence_strap_out,
  input wire logic presence_strap_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req_q1_reg, req_q2_reg;
  logic [15:0] hold_reg, hold_next;
  // two flops like the design sync, so the hold count lines up with it
  always_comb begin
    hold_next = (rst || !req_q2_reg) ? 16'h0000 : hold_reg + 16'h0001;
  end
  always_ff @(posedge clk_sys) begin
    req_q1_reg <= laser_off_request;
    req_q2_reg <= req_q1_reg;
    hold_reg <= hold_next;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_req_high;
    $rose(laser_off_request) ##1 laser_off_request [*5];
  endsequence
  sequence s_fault_up;
    $rose(laser_fault_detect) ##1 laser_fault_detect [*5];
  endsequence
  a_off_fast: assert property (s_req_high |-> !laser_enable)
    else $error("laser still on after off request");
  a_fault_fast: assert property (s_fault_up |-> !laser_fault_flag_oe)
    else $error("fault pin not released after fault");
  a_fault_latched: assert property ((!laser_off_request) [*4] ##0 !laser_fault_flag_oe
    |=> !laser_fault_flag_oe)
    else $error("fault flag dropped without clear pulse");
  a_clear_hold: assert property ($rose(laser_fault_flag_oe)
    |-> hold_reg >= CLEAR_CYCLES - 2)
    else $error("fault cleared by too short a pulse");
  a_rxlow_set: assert property (rx_power_detect_low [*5] |-> !rx_power_low_flag_oe)
    else $error("loss flag not raised");
  a_rxlow_clear: assert property ((!rx_power_detect_low) [*5] |-> rx_power_low_flag_oe)
    else $error("loss flag not cleared");
  a_init_dark: assert property ($rose(laser_fault_flag_oe) |-> !laser_enable [*8])
    else $error("laser on during init after clear");
  a_dark_on_fault: assert property (laser_enable |-> laser_fault_flag_oe)
    else $error("laser on while fault latched");
  a_strap_ground: assert property (presence_strap_oe && !presence_strap_out)
    else $error("presence strap not grounded");
  a_open_drain: assert property (!laser_fault_flag_out && !rx_power_low_flag_out
    && !id_link_data_line_out)
    else $error("open-drain pin drives high");
endmodule

bind poc_ctrl poc_ctrl_monitor #(.INIT_CYCLES(INIT_CYCLES), .CLEAR_CYCLES(CLEAR_CYCLES)) u_mon (
  .clk_sys(clk_sys), .rst(rst), .laser_off_request(laser_off_request),
  .laser_fault_detect(laser_fault_detect), .rx_power_detect_low(rx_power_detect_low),
  .id_link_clock_line(id_link_clock_line), .id_link_data_line_in(id_link_data_line_in),
  .id_link_data_line_out(id_link_data_line_out), .id_link_data_line_oe(id_link_data_line_oe),
  .laser_enable(laser_enable), .laser_fault_flag_out(laser_fault_flag_out),
  .laser_fault_flag_oe(laser_fault_flag_oe), .rx_power_low_flag_out(rx_power_low_flag_out),
  .rx_power_low_flag_oe(rx_power_low_flag_oe), .presence_strap_out(presence_strap_out),
  .presence_strap_oe(presence_strap_oe));

// file: bench/poc_host_model.sv
// host board side of the id link: bit-banged two-wire master
// assumes pull-ups on both lines; the device only pulls data low
module poc_host_model
  import poc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic dev_data_oe,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // 125 cycles of 40 ns per half bit keeps the link at 100 kHz
  localparam int HALF = 125;
  logic sda_drv;
  // wired-and of both parties on the data line
  assign sda = sda_drv & !dev_data_oe;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // data moves only mid-low so it never looks like start or stop
  task automatic put_bit(input logic b);
    hw(HALF / 2);
    sda_drv = b;
    hw(HALF / 2);
    scl = 1'b1;
    hw(HALF);
    scl = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    hw(HALF / 2);
    sda_drv = 1'b1;
    hw(HALF / 2);
    scl = 1'b1;
    hw(HALF);
    b = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    sda_drv = 1'b1;
    hw(HALF);
    scl = 1'b1;
    hw(HALF);
    sda_drv = 1'b0;
    hw(HALF);
    scl = 1'b0;
  endtask
  task automatic stop();
    hw(HALF / 2);
    sda_drv = 1'b0;
    hw(HALF);
    scl = 1'b1;
    hw(HALF);
    sda_drv = 1'b1;
    hw(HALF);
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(ack);
  endtask
  // pointer write, repeated start, one byte read, nack, stop
  task automatic read_status(output logic [7:0] v, output logic [2:0] acks);
    start();
    send_byte({DIAG_DEV_ADDR, 1'b0}, acks[2]);
    send_byte(STATUS_BYTE_ADDR, acks[1]);
    start();
    send_byte({DIAG_DEV_ADDR, 1'b1}, acks[0]);
    for (int i = 7; i >= 0; i--) get_bit(v[i]);
    put_bit(1'b1);
    stop();
  endtask
  task automatic probe(input logic [6:0] addr, output logic ack);
    start();
    send_byte({addr, 1'b0}, ack);
    stop();
  endtask
endmodule

// file: bench/poc_ctrl_tb.sv
// self-checking bench for the control pin block
// assumes the host model drives the id link and the checker is bound
module poc_ctrl_tb
  import poc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INIT_N = 50;
  localparam int CLEAR_N = 20;
  localparam int LIMIT = 60000;
  logic clk_sys, rst, req, fault_det, rx_low, scl, sda;
  logic data_out, data_oe, laser_en, f_out, f_oe, l_out, l_oe, s_out, s_oe;
  logic f_pin, l_pin, s_pin, ack;
  logic [7:0] v;
  logic [2:0] acks;
  int fail_count, comparisons, cycles;
  // pull-ups on the host board resolve the open-drain pins
  assign f_pin = f_oe ? f_out : 1'b1;
  assign l_pin = l_oe ? l_out : 1'b1;
  assign s_pin = s_oe ? s_out : 1'b1;
  poc_ctrl #(.INIT_CYCLES(INIT_N), .CLEAR_CYCLES(CLEAR_N)) u_poc_ctrl (
    .clk_sys(clk_sys), .rst(rst), .laser_off_request(req), .laser_fault_detect(fault_det),
    .rx_power_detect_low(rx_low), .id_link_clock_line(scl), .id_link_data_line_in(sda),
    .id_link_data_line_out(data_out), .id_link_data_line_oe(data_oe), .laser_enable(laser_en),
    .laser_fault_flag_out(f_out), .laser_fault_flag_oe(f_oe), .rx_power_low_flag_out(l_out),
    .rx_power_low_flag_oe(l_oe), .presence_strap_out(s_out), .presence_strap_oe(s_oe));
  poc_host_model u_poc_host_model (
    .clk_sys(clk_sys), .dev_data_oe(data_oe), .scl(scl), .sda(sda));
  always #20 clk_sys = ~clk_sys;
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bit_is(input string name, input logic seen, input logic exp);
    check(name, {7'h00, seen}, {7'h00, exp});
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    req = 1'b0;
    fault_det = 1'b0;
    rx_low = 1'b0;
    wait_n(5);
    rst = 1'b0;
    wait_n(1);
    bit_is("strap", s_pin, 1'b0);
    bit_is("laser_init", laser_en, 1'b0);
    wait_n(INIT_N + 8);
    bit_is("laser_on", laser_en, 1'b1);
    bit_is("fault_pin", f_pin, 1'b0);
    req = 1'b1;
    wait_n(6);
    bit_is("laser_off", laser_en, 1'b0);
    req = 1'b0;
    wait_n(8);
    bit_is("laser_back", laser_en, 1'b1);
    // loss flag and its status bit
    rx_low = 1'b1;
    wait_n(6);
    bit_is("rxlow_pin", l_pin, 1'b1);
    u_poc_host_model.read_status(v, acks);
    check("acks", {5'h00, acks}, 8'h00);
    check("status_rxlow", v, 8'h02);
    rx_low = 1'b0;
    wait_n(6);
    bit_is("rxlow_gone", l_pin, 1'b0);
    // latched fault, short and qualifying clear pulses
    fault_det = 1'b1;
    wait_n(6);
    bit_is("fault_up", f_pin, 1'b1);
    bit_is("laser_dark", laser_en, 1'b0);
    fault_det = 1'b0;
    wait_n(40);
    bit_is("fault_kept", f_pin, 1'b1);
    u_poc_host_model.read_status(v, acks);
    check("status_fault", v, 8'h04);
    req = 1'b1;
    wait_n(CLEAR_N - 5);
    req = 1'b0;
    wait_n(8);
    bit_is("short_pulse", f_pin, 1'b1);
    req = 1'b1;
    wait_n(CLEAR_N + 4);
    bit_is("cleared", f_pin, 1'b0);
    req = 1'b0;
    wait_n(8);
    bit_is("init_dark", laser_en, 1'b0);
    wait_n(INIT_N);
    bit_is("init_done", laser_en, 1'b1);
    // a device address that is not served gets no acknowledge
    u_poc_host_model.probe(7'h50, ack);
    bit_is("no_ack", ack, 1'b1);
    print_verdict();
  end
endmodule
